// *** src/adc_seq_regs.svh ***
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
`define OFS_CTRL 12'h000
`define OFS_SEQ0 12'h008
`define OFS_SEQ1 12'h00c
`define OFS_GDAT0 12'h010
`define OFS_GDAT1 12'h014
`define OFS_RES0 12'h020
`define OFS_RES11 12'h04c
`define OFS_THR_LO 12'h050
`define OFS_THR_HI 12'h054
`define OFS_FLAGS 12'h068
`define F_DIV 7:0
`define F_ASYNC 8
`define F_LOWPWR 10
`define F_THREN 11
`define F_CHAN 11:0
`define F_TRIG 15:12
`define F_POL 18
`define F_EXTRA_SAMPLE_CLOCKS 23:20
`define F_START 26
`define F_BURST 27
`define F_STEP 28
`define F_MODE 30
`define F_ENA 31
`define F_FLAGS 3:0
`define FL_THR 2
`define FL_OVR 3
`define N_CHAN 12
`define N_SYNC 7
`define TRIG_NONE 4'h0
`define TRIG_PIN0 4'h1
`define TRIG_PIN1 4'h2
`define TRIG_TMR3 4'h5
`define TRIG_CMP 4'h6
`define TRIG_PAT 4'h7
`define TRIG_CORE 4'h8
`define RES_MAX 12'hfff
`define RES_MIN 12'h000
`define RST_WORD 32'h0000_0000
`define SAMPLE_HALF_CLKS 6'h0d
`define SAMPLE_CLKS ((`SAMPLE_HALF_CLKS + 6'h01) >> 1)
`define CONV_CLKS 6'h1f
`define MCLK_KHZ 20000
`define CONV_MAX_KHZ 15000
`define MIN_DIV 8'((`MCLK_KHZ + `CONV_MAX_KHZ - 1) / `CONV_MAX_KHZ - 1)
`endif

// *** src/adc_seq_pkg.sv ***
`include "adc_seq_regs.svh"
package adc_seq_pkg;
	typedef enum logic [1:0] {ENG_IDLE, ENG_WAKE, ENG_CONV} eng_state_t;
	typedef struct packed {
		logic [`N_SYNC-1:0] s1;
		logic [`N_SYNC-1:0] s2;
	} sync_state_t;
	typedef struct packed {
		logic [7:0] dcnt;
		logic aprev;
		logic [5:0] cnt;
		logic busy;
		logic sample;
		logic done;
	} timer_state_t;
	typedef struct packed {
		eng_state_t st;
		logic [7:0] div;
		logic async_m;
		logic lowpwr;
		logic thren;
		logic [1:0][31:0] seq;
		logic [`N_CHAN-1:0][11:0] res;
		logic [1:0][15:0] gdat;
		logic [11:0] thr_lo;
		logic [11:0] thr_hi;
		logic above_lo;
		logic [3:0] flags;
		logic [1:0] lvl;
		logic [1:0] busy;
		logic [1:0] credit;
		logic [1:0][3:0] ch;
		logic owner;
		logic [3:0] chan;
		logic go;
		logic power;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} ctl_state_t;
endpackage: adc_seq_pkg

// *** src/trig_sync.sv ***
`include "adc_seq_regs.svh"
module trig_sync (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [`N_SYNC-1:0] raw_i,
	output logic [`N_SYNC-1:0] sync_o
);
	adc_seq_pkg::sync_state_t q;
	adc_seq_pkg::sync_state_t d;

	// RULE26 two-stage synchroniser
	always_comb
	begin
		d = q;
		d.s1 = raw_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else if (ce_i)
			q <= d;
	end

	assign sync_o = q.s2;
endmodule: trig_sync

// *** src/conv_timer.sv ***
`include "adc_seq_regs.svh"
module conv_timer (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic async_mode_i,
	input wire logic async_clk_i,
	input wire logic [7:0] div_i,
	input wire logic start_i,
	input wire logic [3:0] extra_i,
	output logic sample_o,
	output logic busy_o,
	output logic done_o
);
	adc_seq_pkg::timer_state_t q;
	adc_seq_pkg::timer_state_t d;
	logic [7:0] eff_div;
	logic tick;
	logic [5:0] cnt_nx;

	// RULE24 clamp keeps converter clock in range
	// RULE18 zero divider passes clock when slow enough
	assign eff_div = (div_i < `MIN_DIV) ? `MIN_DIV : div_i;
	// RULE19 sync divider or async clock edges
	assign tick = async_mode_i ? (async_clk_i && !q.aprev) : (q.dcnt == eff_div);
	assign cnt_nx = q.cnt + 6'h01;

	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.aprev = async_clk_i;
		d.dcnt = (tick || start_i) ? 8'h00 : q.dcnt + 8'h01;
		if (start_i)
		begin
			d.busy = 1'b1;
			d.sample = 1'b1;
			d.cnt = 6'h00;
		end
		else if (q.busy && tick)
		begin
			d.cnt = cnt_nx;
			// RULE14 sample then convert
			// RULE15 extra sample clocks
			if (cnt_nx == `SAMPLE_CLKS + {2'b00, extra_i})
				d.sample = 1'b0;
			if (cnt_nx == `CONV_CLKS + {2'b00, extra_i})
			begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else if (ce_i)
			q <= d;
	end

	assign sample_o = q.sample;
	assign busy_o = q.busy;
	assign done_o = q.done;
endmodule: conv_timer

// *** src/adc_seq_ctrl.sv ***
// Overview of operation
// RULE1: result is 12-bit, clamped to range
// RULE2: software start launches a conversion
// RULE3: polarity, enable, start in one write
// RULE4: later start writes keep trigger fields
// RULE5: software-only sequences keep trigger zero
// RULE6: channel mask bit n selects input n
// RULE7: trigger code selects hardware source
// RULE8: two independent sequences
// RULE9: trigger starts one step or whole sequence
// RULE10: stepping converts next channel per trigger
// RULE11: positive polarity fires on rising edge
// RULE12: mode one interrupts at sequence end
// RULE13: per-channel result registers
// RULE14: sample 6.5 clocks, conversion 31; the code samples for 7 clocks (SAMPLE_CLKS rounds 6.5 up)
// RULE15: per-sequence extra sample clocks
// RULE16: low power wakes converter on trigger
// RULE17: four separate interrupt outputs
// RULE18: zero divider passes slow clock undivided
// RULE19: synchronous or asynchronous converter clock
// RULE20: twelve inputs multiplexed by mask
// RULE21: threshold and crossing detection flags
// RULE22: burst repeats without triggers
// RULE23: sequence runs until disabled
// RULE24: converter clock at most 15 MHz
// RULE25: all control fields reset to zero
// RULE26: triggers synchronised before edge detect
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`include "adc_seq_regs.svh"
module adc_seq_ctrl (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [5:0] hw_trig_i,
	input wire logic async_clk_i,
	input wire logic [12:0] core_result_i,
	input wire logic core_below_i,
	output logic core_power_o,
	output logic core_sample_o,
	output logic core_convert_o,
	output logic [3:0] core_chan_o,
	output logic [3:0] irq_o
);
	adc_seq_pkg::ctl_state_t q;
	adc_seq_pkg::ctl_state_t d;
	logic [`N_SYNC-1:0] sync_w;
	logic tm_done;
	logic wr;
	logic hit;
	logic in_res;
	logic [3:0] res_idx;
	logic [31:0] rmux;
	logic [1:0] cur_lvl;
	logic [1:0] hw_edge;
	logic [1:0] wr_seq;
	logic [1:0] sw_start;
	logic [1:0] evt;
	logic [1:0] pend;
	logic [1:0][31:0] seq_e;
	logic [1:0][4:0] first;
	logic pick;
	logic [11:0] res_val;
	logic [4:0] nx;
	logic [3:0] set_fl;
	logic [3:0] clr_fl;

	// RULE7 trigger source decode
	function automatic logic trig_pick(input logic [3:0] code, input logic [5:0] t);
		logic r;
		r = 1'b0;
		case (code)
			`TRIG_PIN0: r = t[0];
			`TRIG_PIN1: r = t[1];
			`TRIG_TMR3: r = t[2];
			`TRIG_CMP: r = t[3];
			`TRIG_PAT: r = t[4];
			`TRIG_CORE: r = t[5];
			default: r = 1'b0;
		endcase
		return r;
	endfunction: trig_pick

	// lowest selected channel above cur, or lowest at all
	function automatic logic [4:0] nxt_sel(input logic [11:0] mask, input logic [3:0] cur, input logic from0);
		logic [4:0] r;
		r = 5'h00;
		for (int i = `N_CHAN - 1; i >= 0; i--)
		begin
			if (mask[i] && (from0 || 4'(i) > cur))
				r = {1'b1, 4'(i)};
		end
		return r;
	endfunction: nxt_sel

	trig_sync u_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.raw_i({async_clk_i, hw_trig_i}),
		.sync_o(sync_w)
	);

	conv_timer u_timer (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.async_mode_i(q.async_m),
		.async_clk_i(sync_w[`N_SYNC-1]),
		.div_i(q.div),
		.start_i(q.go),
		.extra_i(q.seq[q.owner][`F_EXTRA_SAMPLE_CLOCKS]),
		.sample_o(core_sample_o),
		.busy_o(core_convert_o),
		.done_o(tm_done)
	);

	assign wr = psel_i && penable_i && pwrite_i && q.ready;
	assign pend = q.busy & q.credit;
	assign pick = !pend[0];
	assign nx = nxt_sel(q.seq[q.owner][`F_CHAN], q.chan, 1'b0);
	assign clr_fl = (wr && paddr_i == `OFS_FLAGS) ? pwdata_i[`F_FLAGS] : 4'h0;
	// RULE1 clamp below and above the reference span
	assign res_val = core_below_i ? `RES_MIN :
		(core_result_i > {1'b0, `RES_MAX}) ? `RES_MAX : core_result_i[11:0];
	assign in_res = paddr_i >= `OFS_RES0 && paddr_i <= `OFS_RES11 && paddr_i[1:0] == 2'b00;
	assign res_idx = 4'((paddr_i - `OFS_RES0) >> 2);

	// RULE8 one trigger path per sequence
	for (genvar gs = 0; gs < 2; gs++)
	begin : g_seq
		assign wr_seq[gs] = wr && paddr_i == (gs == 0 ? `OFS_SEQ0 : `OFS_SEQ1);
		assign seq_e[gs] = wr_seq[gs] ? pwdata_i : q.seq[gs];
		// RULE11 polarity folded in before edge detect
		assign cur_lvl[gs] = trig_pick(q.seq[gs][`F_TRIG], sync_w[5:0]) ^ !q.seq[gs][`F_POL];
		// RULE5 code zero never fires
		assign hw_edge[gs] = cur_lvl[gs] && !q.lvl[gs] && q.seq[gs][`F_TRIG] != `TRIG_NONE;
		// RULE3 start acts with enable from the same write
		assign sw_start[gs] = wr_seq[gs] && pwdata_i[`F_START] && pwdata_i[`F_ENA];
		// RULE22 burst restarts an idle sequence
		assign evt[gs] = seq_e[gs][`F_ENA] && (sw_start[gs] || hw_edge[gs] ||
			(seq_e[gs][`F_BURST] && !q.busy[gs]));
		// RULE6 mask bit n selects input n
		assign first[gs] = nxt_sel(seq_e[gs][`F_CHAN], 4'h0, 1'b1);
	end

	always_comb
	begin
		rmux = `RST_WORD;
		hit = 1'b1;
		case (paddr_i)
			`OFS_CTRL: rmux = {20'h00000, q.thren, q.lowpwr, 1'b0, q.async_m, q.div};
			`OFS_SEQ0: rmux = q.seq[0];
			`OFS_SEQ1: rmux = q.seq[1];
			`OFS_GDAT0: rmux = {16'h0000, q.gdat[0]};
			`OFS_GDAT1: rmux = {16'h0000, q.gdat[1]};
			`OFS_THR_LO: rmux = {20'h00000, q.thr_lo};
			`OFS_THR_HI: rmux = {20'h00000, q.thr_hi};
			`OFS_FLAGS: rmux = {28'h0000000, q.flags};
			default:
			begin
				hit = in_res;
				if (in_res)
					rmux = {20'h00000, q.res[res_idx]};
			end
		endcase
	end

	always_comb
	begin
		d = q;
		set_fl = 4'h0;
		d.go = 1'b0;
		d.lvl = cur_lvl;
		d.ready = psel_i && penable_i && !q.ready;
		d.err = psel_i && penable_i && !q.ready && !hit;
		if (d.ready)
			d.rdata = rmux;
		if (wr && paddr_i == `OFS_CTRL)
		begin
			d.div = pwdata_i[`F_DIV];
			d.async_m = pwdata_i[`F_ASYNC];
			d.lowpwr = pwdata_i[`F_LOWPWR];
			d.thren = pwdata_i[`F_THREN];
		end
		if (wr && paddr_i == `OFS_THR_LO)
			d.thr_lo = pwdata_i[11:0];
		if (wr && paddr_i == `OFS_THR_HI)
			d.thr_hi = pwdata_i[11:0];
		// RULE16 powered while any sequence is pending
		d.power = !q.lowpwr || q.busy != 2'b00 || q.st != adc_seq_pkg::ENG_IDLE;
		unique case (q.st)
			adc_seq_pkg::ENG_IDLE:
			begin
				if (pend != 2'b00)
				begin
					if (q.power)
					begin
						d.st = adc_seq_pkg::ENG_CONV;
						d.owner = pick;
						// RULE20 input mux select
						d.chan = q.ch[pick];
						d.go = 1'b1;
						// RULE10 one conversion per trigger
						if (q.seq[pick][`F_STEP])
							d.credit[pick] = 1'b0;
					end
					else
						d.st = adc_seq_pkg::ENG_WAKE;
				end
			end
			adc_seq_pkg::ENG_WAKE:
			begin
				if (q.power)
					d.st = adc_seq_pkg::ENG_IDLE;
			end
			adc_seq_pkg::ENG_CONV:
			begin
				if (tm_done)
				begin
					d.st = adc_seq_pkg::ENG_IDLE;
					// RULE13 per-channel and global result
					d.res[q.chan] = res_val;
					d.gdat[q.owner] = {q.chan, res_val};
					// RULE21 window and crossing detection
					if (q.thren)
					begin
						if (res_val < q.thr_lo || res_val > q.thr_hi || (res_val >= q.thr_lo) != q.above_lo)
							set_fl[`FL_THR] = 1'b1;
						d.above_lo = res_val >= q.thr_lo;
					end
					if (q.busy[q.owner])
					begin
						if (nx[4])
							d.ch[q.owner] = nx[3:0];
						else
						begin
							d.busy[q.owner] = 1'b0;
							d.credit[q.owner] = 1'b0;
						end
						// RULE12 end-of-sequence or per-conversion flag
						if (!q.seq[q.owner][`F_MODE] || !nx[4])
							set_fl[q.owner] = 1'b1;
					end
				end
			end
		endcase
		for (int s = 0; s < 2; s++)
		begin
			if (wr_seq[s])
			begin
				d.seq[s] = pwdata_i;
				d.seq[s][`F_START] = 1'b0;
			end
			// RULE23 sequence stays armed until disabled
			if (!seq_e[s][`F_ENA])
			begin
				d.busy[s] = 1'b0;
				d.credit[s] = 1'b0;
			end
			// RULE9 start step or whole sequence
			// RULE2 software start converts
			else if (evt[s])
			begin
				if (!d.busy[s])
				begin
					if (|seq_e[s][`F_CHAN])
					begin
						d.busy[s] = 1'b1;
						d.credit[s] = 1'b1;
						d.ch[s] = first[s][3:0];
					end
				end
				else if (!d.credit[s])
					d.credit[s] = 1'b1;
				else
					set_fl[`FL_OVR] = 1'b1;
			end
		end
		// RULE17 sticky flags, set wins over clear
		d.flags = (q.flags & ~clr_fl) | set_fl;
	end

	// RULE25 everything clears to zero
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else if (ce_i)
			q <= d;
	end

	assign prdata_o = q.rdata;
	assign pready_o = q.ready;
	assign pslverr_o = q.err;
	assign core_power_o = q.power;
	assign core_chan_o = q.chan;
	assign irq_o = q.flags;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);

	sat_result_a: assert property ( // RULE1
		ce_i && q.st == adc_seq_pkg::ENG_CONV && tm_done && !core_below_i && core_result_i > {1'b0, `RES_MAX}
		|=> q.gdat[$past(q.owner)][11:0] == `RES_MAX)
		else $error("over-range result not saturated");

	sw_start_a: assert property ( // RULE2
		ce_i && sw_start[0] && !q.busy[0] && |pwdata_i[`F_CHAN] |=> q.busy[0] && q.credit[0])
		else $error("software start did not arm sequence");

	comb_write_a: assert property ( // RULE3
		ce_i && sw_start[1] && pwdata_i[`F_POL] && |pwdata_i[`F_CHAN] && !q.busy[1]
		|=> q.seq[1][`F_ENA] && q.seq[1][`F_POL] && !q.seq[1][`F_START] && q.busy[1])
		else $error("combined write not acted on");

	step_credit_a: assert property ( // RULE10
		ce_i && q.st == adc_seq_pkg::ENG_IDLE && q.power && pend[0] && q.seq[0][`F_STEP] && !evt[0]
		|=> q.st == adc_seq_pkg::ENG_CONV && !q.credit[0] && core_chan_o == $past(q.ch[0]))
		else $error("stepping did not consume credit");

	rise_edge_a: assert property ( // RULE11
		ce_i && q.seq[1][`F_POL] && hw_edge[1] && q.seq[1][`F_ENA] && !wr_seq[1] && !q.busy[1] && |q.seq[1][`F_CHAN]
		|=> q.busy[1])
		else $error("rising trigger edge ignored");

	end_irq_a: assert property ( // RULE12
		ce_i && q.st == adc_seq_pkg::ENG_CONV && tm_done && q.busy[q.owner] && q.seq[q.owner][`F_MODE] && nx[4]
		&& !q.flags[q.owner] |=> !q.flags[$past(q.owner)])
		else $error("interrupt raised before sequence end");

	store_res_a: assert property ( // RULE13
		ce_i && q.st == adc_seq_pkg::ENG_CONV && tm_done |=> q.res[$past(q.chan)] == $past(res_val))
		else $error("result not stored for channel");

	wake_power_a: assert property ( // RULE16
		ce_i && q.busy != 2'b00 |=> q.power)
		else $error("converter not powered while pending");

	keep_run_a: assert property ( // RULE23
		ce_i && q.busy[0] && q.seq[0][`F_ENA] && !wr_seq[0] && !(tm_done && q.st == adc_seq_pkg::ENG_CONV)
		|=> q.busy[0])
		else $error("sequence dropped while enabled");
endmodule: adc_seq_ctrl

// *** verification/adc_core_model.sv ***
module adc_core_model (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic core_convert_i,
	input wire logic [3:0] core_chan_i,
	output logic [12:0] core_result_o,
	output logic core_below_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hold_q;
	logic [12:0] idle_q;
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			hold_q <= 1'b0;
			idle_q <= 13'h0aaa;
		end
		else
		begin
			hold_q <= core_convert_i;
			idle_q <= ~idle_q;
		end
	end
	// input 2 below range, input 3 above
	always_comb
	begin
		if (core_convert_i || hold_q)
		begin
			core_result_o = (core_chan_i == 4'h3) ? 13'h1abc : {9'h000, core_chan_i} + 13'h0100;
			core_below_o = (core_chan_i == 4'h2);
		end
		else
		begin
			core_result_o = idle_q;
			core_below_o = idle_q[0];
		end
	end
endmodule: adc_core_model

// *** verification/adc_seq_ctrl_tb.sv ***
module adc_seq_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i, nrst_i, psel, penable, pwrite, aclk, pready, pslverr, err;
	logic power, sample, convert, below, cv_q, sp_q, ce;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] trig;
	logic [12:0] result;
	logic [3:0] chan, irq;
	logic [3:0] chans[$];
	int num_errors, total_checks, conv_len, samp_len, cnt_c, cnt_s, done_n;

	adc_seq_ctrl adc_seq_ctrl_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .hw_trig_i(trig), .async_clk_i(aclk),
		.core_result_i(result), .core_below_i(below), .core_power_o(power), .core_sample_o(sample),
		.core_convert_o(convert), .core_chan_o(chan), .irq_o(irq));
	adc_core_model adc_core_model_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .core_convert_i(convert),
		.core_chan_i(chan), .core_result_o(result), .core_below_o(below));

	initial
	begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	initial
	begin
		aclk = 1'b0;
		forever #100 aclk = ~aclk;
	end

	// conversion monitor: channel order and phase lengths
	always @(posedge mclk_i)
	begin
		if (convert === 1'b1 && cv_q !== 1'b1)
			chans.push_back(chan);
		if (convert !== 1'b1 && cv_q === 1'b1)
		begin
			conv_len = cnt_c;
			done_n++;
		end
		if (sample !== 1'b1 && sp_q === 1'b1)
			samp_len = cnt_s;
		cnt_c = (convert === 1'b1) ? cnt_c + 1 : 0;
		cnt_s = (sample === 1'b1) ? cnt_s + 1 : 0;
		cv_q = convert;
		sp_q = sample;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask: chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		@(posedge mclk_i);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge mclk_i);
			n++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_i);
		chk(n < 20, 1);
	endtask: apb

	task automatic wait_ev(input int b, input int n);
		int k;
		k = 0;
		while ((b < 4 ? irq[b] !== 1'b1 : done_n < n) && k < 2000)
		begin
			@(posedge mclk_i);
			k++;
		end
		chk(k < 2000, 1);
		repeat (3) @(posedge mclk_i);
	endtask: wait_ev

	task automatic pulse(input int b);
		trig[b] <= 1'b1;
		repeat (4) @(posedge mclk_i);
		trig[b] <= 1'b0;
		@(posedge mclk_i);
	endtask: pulse

	task automatic s_reset();
		apb(0, 12'h000, 0);
		chk(rd, 0);
		apb(0, 12'h008, 0);
		chk(rd, 0);
		apb(0, 12'h00c, 0);
		chk(rd, 0);
		apb(0, 12'h004, 0);
		chk(rd, 0);
		chk(err, 1);
	endtask: s_reset

	task automatic s_swstart();
		chans.delete();
		apb(1, 12'h000, 32'h1);
		apb(1, 12'h008, 32'hc404_0002);
		wait_ev(0, 0);
		chk(chans[0], 1);
		chk(conv_len, 62);
		chk(samp_len, 14);
		chk(irq, 32'h1);
		apb(0, 12'h024, 0);
		chk(rd, 32'h101);
		apb(1, 12'h068, 32'hf);
		apb(1, 12'h008, 32'hc404_0002);
		// clock enable low stretches the running conversion
		repeat (10) @(posedge mclk_i);
		ce <= 1'b0;
		repeat (20) @(posedge mclk_i);
		ce <= 1'b1;
		wait_ev(0, 0);
		chk(chans.size(), 2);
		chk(conv_len, 82);
		chk(samp_len, 34);
		apb(1, 12'h068, 32'hf);
	endtask: s_swstart

	task automatic s_whole();
		chans.delete();
		apb(1, 12'h008, 32'hc004_100f);
		pulse(0);
		wait_ev(0, 0);
		chk({chans[0], chans[1], chans[2], chans[3]}, 16'h0123);
		for (int i = 0; i < 4; i++)
		begin
			apb(0, 12'h020 + 12'(4 * i), 0);
			chk(rd, (i == 2) ? 32'h0 : (i == 3) ? 32'hfff : 32'h100 + i);
		end
		apb(1, 12'h068, 32'hf);
	endtask: s_whole

	task automatic s_step();
		chans.delete();
		apb(1, 12'h008, 32'hd004_5005);
		pulse(2);
		wait_ev(4, done_n + 1);
		chk(irq[0], 0);
		chk(chans.size(), 1);
		pulse(2);
		wait_ev(0, 0);
		chk({chans[0], chans[1]}, 8'h02);
		apb(1, 12'h008, 32'h0);
		apb(1, 12'h068, 32'hf);
	endtask: s_step

	task automatic s_table();
		int codes[6] = '{1, 2, 5, 6, 7, 8};
		int n;
		for (int i = 0; i < 6; i++)
		begin
			apb(1, 12'h00c, 32'hc034_0010 | (32'(codes[i]) << 12));
			pulse(i);
			wait_ev(1, 0);
			chk(chans[$], 4);
			chk(conv_len, 68);
			chk(samp_len, 20);
			apb(1, 12'h068, 32'hf);
		end
		apb(0, 12'h014, 0);
		chk(rd, 32'h4104);
		chk(irq[0], 0);
		n = chans.size();
		apb(1, 12'h00c, 32'h4034_8010);
		pulse(5);
		repeat (150) @(posedge mclk_i);
		chk(chans.size(), n);
	endtask: s_table

	task automatic s_lowpwr();
		int k;
		k = 0;
		apb(1, 12'h000, 32'h401);
		@(posedge mclk_i);
		chk(power, 0);
		apb(1, 12'h008, 32'hc404_0002);
		while (convert !== 1'b1 && k < 20)
		begin
			@(posedge mclk_i);
			k++;
		end
		chk(power, 1);
		wait_ev(0, 0);
		chk(power, 0);
		apb(1, 12'h068, 32'hf);
	endtask: s_lowpwr

	task automatic s_extra();
		int n;
		apb(1, 12'h050, 32'h200);
		apb(1, 12'h054, 32'h300);
		apb(1, 12'h000, 32'h800);
		apb(1, 12'h008, 32'h8404_0002);
		apb(1, 12'h008, 32'h8404_0002);
		wait_ev(2, 0);
		chk(conv_len, 62);
		chk(irq, 32'hd);
		apb(0, 12'h010, 0);
		chk(rd, 32'h1101);
		apb(1, 12'h068, 32'hf);
		chk(irq, 0);
		apb(1, 12'h000, 32'h001);
		apb(1, 12'h008, 32'h8800_0002);
		wait_ev(4, done_n + 3);
		apb(1, 12'h008, 32'h0);
		repeat (5) @(posedge mclk_i);
		n = chans.size();
		repeat (100) @(posedge mclk_i);
		chk(chans.size(), n);
		apb(1, 12'h068, 32'hf);
		apb(1, 12'h000, 32'h101);
		apb(1, 12'h00c, 32'h8404_0010);
		wait_ev(1, 0);
		chk(conv_len > 120 && conv_len < 125, 1);
		apb(1, 12'h068, 32'hf);
		apb(1, 12'h000, 32'h001);
		// falling polarity: arm disabled first so no edge appears
		n = chans.size();
		apb(1, 12'h00c, 32'h0000_1010);
		apb(1, 12'h00c, 32'hc000_1010);
		trig[0] <= 1'b1;
		repeat (10) @(posedge mclk_i);
		chk(chans.size(), n);
		trig[0] <= 1'b0;
		wait_ev(1, 0);
		chk(chans.size(), n + 1);
		apb(1, 12'h00c, 32'h0);
		apb(1, 12'h068, 32'hf);
	endtask: s_extra

	task automatic tally_and_finish();
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask: tally_and_finish

	initial
	begin
		nrst_i = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, trig} = '0;
		ce = 1'b1;
		repeat (3) @(posedge mclk_i);
		nrst_i <= 1'b1;
		s_reset();
		s_swstart();
		s_whole();
		s_step();
		s_table();
		s_lowpwr();
		s_extra();
		tally_and_finish();
	end

	initial
	begin
		#(50 * 20000);
		num_errors++;
		tally_and_finish();
	end
endmodule: adc_seq_ctrl_tb
